/* File: hw/cag_pkg.sv */
// Package: constants and carrier types for the coprocessor access gate
`default_nettype none
package cag_pkg;

    // -----------------------------------------------------------------
    // Instruction fields
    // -----------------------------------------------------------------
    localparam int unsigned OPC_HI        = 31;
    localparam int unsigned OPC_LO        = 26;
    localparam int unsigned COPNUM_HI     = 27;
    localparam int unsigned COPNUM_LO     = 26;
    localparam int unsigned RS_HI         = 25;
    localparam int unsigned RS_LO         = 21;
    localparam int unsigned RT_HI         = 20;
    localparam int unsigned RT_LO         = 16;
    localparam int unsigned RD_HI         = 15;
    localparam int unsigned RD_LO         = 11;
    localparam int unsigned COND_HI       = 20;
    localparam int unsigned COND_LO       = 16;
    localparam int unsigned OFFS_HI       = 15;
    localparam int unsigned OFFS_LO       = 0;
    localparam int unsigned FUNC_HI       = 24;
    localparam int unsigned FUNC_LO       = 0;
    localparam int unsigned CO_BIT        = 25;
    localparam logic [3:0]  OPC_COP_TOP   = 4'h4;
    localparam logic [4:0]  RS_CTL_READ   = 5'h02;
    localparam logic [4:0]  RS_BRANCH     = 5'h08;
    localparam logic [1:0]  PRIV_KERNEL   = 2'h0;

    // -----------------------------------------------------------------
    // APB register map
    // -----------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS    = 12'h000;
    localparam logic [11:0] OFS_MASK      = 12'h004;
    localparam logic [11:0] OFS_CTRL      = 12'h008;
    localparam logic [11:0] OFS_LAST      = 12'h00c;
    localparam logic [11:0] OFS_COUNT     = 12'h010;
    localparam int unsigned EV_UNUSABLE   = 0;
    localparam int unsigned EV_RESERVED   = 1;
    localparam int unsigned EV_BRANCH     = 2;
    localparam int unsigned EV_READ       = 3;
    localparam int unsigned EV_OPERATE    = 4;
    localparam int unsigned EV_W          = 5;
    localparam logic [4:0]  MASK_RST      = 5'h00;
    localparam logic [2:0]  CTRL_RST      = 3'h0;
    localparam int unsigned CTRL_ENABLE   = 0;
    localparam int unsigned CTRL_ZERO_UNK = 1;
    localparam int unsigned CTRL_CLR_CNT  = 2;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        CAG_EXC_NONE     = 3'b000,
        CAG_EXC_UNUSABLE = 3'b001,
        CAG_EXC_RESERVED = 3'b010
    } cag_exc_t;

    typedef struct packed {
        logic [1:0] privilege_level_field;
        logic       exception_level_bit;
        logic       error_level_bit;
        logic       debug_active_bit;
        logic [3:0] cop_usable_bit;
    } cag_mode_t;

    typedef struct packed {
        logic [3:0] cond_branch_impl;
        logic [3:0] control_read_impl;
        logic [3:0] operate_impl;
        logic [3:0] ctl_reg_present;
    } cag_impl_t;

endpackage : cag_pkg
`default_nettype wire

/* File: hw/cag_access_check.sv */
// Access rights check for one coprocessor instruction
`timescale 1ns/1ps
`default_nettype none
module cag_access_check
    import cag_pkg::*;
(
    input  wire cag_mode_t  mode,
    input  wire logic [1:0] cop_num,
    output logic            allowed
);
    // -----------------------------------------------------------------
    // Usable bit or coprocessor 0 privilege override
    // -----------------------------------------------------------------
    logic override;
    assign override = (cop_num == 2'h0) &&
        ((mode.privilege_level_field == PRIV_KERNEL) ||
         mode.exception_level_bit || mode.error_level_bit ||
         mode.debug_active_bit);
    assign allowed = mode.cop_usable_bit[cop_num] || override;
endmodule : cag_access_check
`default_nettype wire

/* File: hw/cag_gate.sv */
// Coprocessor access gate: checks, branch target and register file
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Unusable exception tagged z when access denied
// - Cop 0 allowed in kernel, exl, erl, debug
// - Target is slot address plus offset times four
// - Cop 0 branch or control read reserved
// - Unimplemented branch raises reserved exception
// - Unimplemented control read raises reserved exception
// - Control register sign-extended into general register
// - Missing control register stays bounded
// - Operate passes low 25 bits to z
// - Unimplemented operate reserved, cop 0 included
// - Access check precedes reserved checks
// - Unpredictable results use only accessible state
// - Unpredictable ops touch no forbidden state
// - Unpredictable ops never hang the processor
// - Any reset restores operation
module cag_gate
    import cag_pkg::*;
#(
    parameter int unsigned XLEN = 64,
    parameter int unsigned CLEN = 32
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             issue_valid,
    input  wire logic [31:0]      issue_instr,
    input  wire logic [XLEN-1:0]  issue_pc,
    input  wire cag_mode_t        mode,
    input  wire cag_impl_t        impl,
    input  wire logic [31:0]      cop_cond,
    input  wire logic [CLEN-1:0]  cop_ctl_data,
    output logic      [1:0]       cop_num,
    output logic      [4:0]       cop_ctl_addr,
    output logic                  cop_op_valid,
    output logic      [24:0]      cop_op_func,
    output logic                  exc_valid,
    output cag_exc_t              exc_code,
    output logic      [1:0]       exc_cop,
    output logic                  branch_taken,
    output logic      [XLEN-1:0]  branch_target,
    output logic                  gpr_we,
    output logic      [4:0]       gpr_addr,
    output logic      [XLEN-1:0]  gpr_wdata,
    output logic                  irq
);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [XLEN-1:0] sext_ctl(
        input logic [CLEN-1:0] v
    );
        sext_ctl = {{(XLEN-CLEN){v[CLEN-1]}}, v};
    endfunction : sext_ctl

    function automatic logic [XLEN-1:0] br_off(input logic [15:0] o);
        br_off = {{(XLEN-18){o[15]}}, o, 2'b00};
    endfunction : br_off

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    logic [4:0]  rs_f;
    logic        is_cop;
    logic        is_br;
    logic        is_rd;
    logic        is_op;
    logic        allowed;
    logic [2:0]  ctrl_reg;
    logic        active;

    assign active  = issue_valid && ctrl_reg[CTRL_ENABLE];
    assign cop_num = issue_instr[COPNUM_HI:COPNUM_LO];
    assign rs_f    = issue_instr[RS_HI:RS_LO];
    assign is_cop  = active &&
        (issue_instr[OPC_HI:OPC_LO+2] == OPC_COP_TOP);
    assign is_op   = is_cop && issue_instr[CO_BIT];
    assign is_br   = is_cop && !issue_instr[CO_BIT] && (rs_f == RS_BRANCH);
    assign is_rd   = is_cop && !issue_instr[CO_BIT] && (rs_f == RS_CTL_READ);

    cag_access_check u_check (
        .mode    (mode),
        .cop_num (cop_num),
        .allowed (allowed)
    );

    // -----------------------------------------------------------------
    // Exception selection
    // -----------------------------------------------------------------
    logic     recognised;
    logic     resv;
    cag_exc_t exc_next;

    assign recognised = is_br || is_rd || is_op;
    always_comb begin
        resv = 1'b0;
        if (is_br) begin
            resv = (cop_num == 2'h0) ||
                   !impl.cond_branch_impl[cop_num];
        end else if (is_rd) begin
            resv = (cop_num == 2'h0) ||
                   !impl.control_read_impl[cop_num];
        end else if (is_op) begin
            resv = !impl.operate_impl[cop_num];
        end
    end

    always_comb begin
        exc_next = CAG_EXC_NONE;
        if (recognised) begin
            if (!allowed) begin
                exc_next = CAG_EXC_UNUSABLE;
            end else if (resv) begin
                exc_next = CAG_EXC_RESERVED;
            end
        end
    end

    logic good;
    assign good = recognised && (exc_next == CAG_EXC_NONE);

    // -----------------------------------------------------------------
    // Outputs towards coprocessors
    // -----------------------------------------------------------------
    assign cop_ctl_addr = issue_instr[RD_HI:RD_LO];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cop_op_valid <= 1'b0;
            cop_op_func  <= 25'h0000000;
        end else begin
            cop_op_valid <= good && is_op;
            cop_op_func  <= (good && is_op) ?
                issue_instr[FUNC_HI:FUNC_LO] : 25'h0000000;
        end
    end

    // -----------------------------------------------------------------
    // Exception report
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_valid <= 1'b0;
            exc_code  <= CAG_EXC_NONE;
            exc_cop   <= 2'h0;
        end else begin
            exc_valid <= exc_next != CAG_EXC_NONE;
            exc_code  <= exc_next;
            exc_cop   <= cop_num;
        end
    end

    // -----------------------------------------------------------------
    // Branch resolved into the delay slot cycle
    // -----------------------------------------------------------------
    logic [XLEN-1:0] slot_pc;
    logic [4:0]      cond_idx;
    assign slot_pc  = issue_pc + XLEN'(4);
    assign cond_idx = {cop_num, issue_instr[COND_HI:COND_LO+2]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            branch_taken  <= 1'b0;
            branch_target <= '0;
        end else begin
            branch_taken  <= good && is_br &&
                cop_cond[cond_idx];
            branch_target <= slot_pc +
                br_off(issue_instr[OFFS_HI:OFFS_LO]);
        end
    end

    // -----------------------------------------------------------------
    // Control register read into the general register
    // -----------------------------------------------------------------
    logic            present;
    logic [XLEN-1:0] rd_value;
    assign present  = impl.ctl_reg_present[cop_num];
    // Absent register gives zero or the coprocessor's own bus only
    assign rd_value = (present || !ctrl_reg[CTRL_ZERO_UNK]) ?
        sext_ctl(cop_ctl_data) : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpr_we    <= 1'b0;
            gpr_addr  <= 5'h00;
            gpr_wdata <= '0;
        end else begin
            gpr_we    <= good && is_rd;
            gpr_addr  <= issue_instr[RT_HI:RT_LO];
            gpr_wdata <= rd_value;
        end
    end

    // -----------------------------------------------------------------
    // APB slave, always ready in one access cycle
    // -----------------------------------------------------------------
    logic       wr_en;
    logic [4:0] status_reg;
    logic [4:0] mask_reg;
    logic [7:0] last_reg;
    logic [15:0] count_reg;
    logic [4:0] ev;
    logic       mapped;

    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign mapped  = (paddr == OFS_STATUS) || (paddr == OFS_MASK) ||
                     (paddr == OFS_CTRL) || (paddr == OFS_LAST) ||
                     (paddr == OFS_COUNT);
    assign pslverr = psel && penable && !mapped;

    assign ev[EV_UNUSABLE] = exc_next == CAG_EXC_UNUSABLE;
    assign ev[EV_RESERVED] = exc_next == CAG_EXC_RESERVED;
    assign ev[EV_BRANCH]   = good && is_br;
    assign ev[EV_READ]     = good && is_rd;
    assign ev[EV_OPERATE]  = good && is_op;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 5'h00;
        end else begin
            status_reg <= (status_reg &
                ~((wr_en && paddr == OFS_STATUS) ? pwdata[4:0] : 5'h00))
                | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= MASK_RST;
            ctrl_reg <= CTRL_RST;
        end else begin
            if (wr_en && paddr == OFS_MASK) begin
                mask_reg <= pwdata[4:0];
            end
            if (wr_en && paddr == OFS_CTRL) begin
                ctrl_reg <= pwdata[2:0];
            end else begin
                ctrl_reg[CTRL_CLR_CNT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg  <= 8'h00;
            count_reg <= 16'h0000;
        end else begin
            if (exc_next != CAG_EXC_NONE) begin
                last_reg <= {3'h0, cop_num, exc_next};
            end
            if (ctrl_reg[CTRL_CLR_CNT]) begin
                count_reg <= 16'h0000;
            end else if (exc_next != CAG_EXC_NONE) begin
                count_reg <= count_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_STATUS: prdata <= {27'h0, status_reg};
                OFS_MASK:   prdata <= {27'h0, mask_reg};
                OFS_CTRL:   prdata <= {29'h0, ctrl_reg};
                OFS_LAST:   prdata <= {24'h0, last_reg};
                OFS_COUNT:  prdata <= {16'h0, count_reg};
                default:    prdata <= 32'h00000000;
            endcase
        end
    end

    assign irq = |(status_reg & mask_reg);

endmodule : cag_gate
`default_nettype wire

/* File: tb/cag_gate_assertions.sv */
// Checker: port assertions for the access gate
`timescale 1ns/1ps
`default_nettype none
module cag_gate_assertions
    import cag_pkg::*;
#(
    parameter int unsigned XLEN = 64,
    parameter int unsigned CLEN = 32
)
(
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pready,
    input wire logic            issue_valid,
    input wire logic [31:0]     issue_instr,
    input wire logic [XLEN-1:0] issue_pc,
    input wire cag_mode_t       mode,
    input wire cag_impl_t       impl,
    input wire logic [31:0]     cop_cond,
    input wire logic [CLEN-1:0] cop_ctl_data,
    input wire logic            exc_valid,
    input wire cag_exc_t        exc_code,
    input wire logic [1:0]      exc_cop,
    input wire logic            branch_taken,
    input wire logic [XLEN-1:0] branch_target,
    input wire logic            gpr_we,
    input wire logic [4:0]      gpr_addr,
    input wire logic [XLEN-1:0] gpr_wdata,
    input wire logic            cop_op_valid,
    input wire logic [24:0]     cop_op_func
);
    // ----
    // Helpers
    // ----
    logic [1:0]      z;
    logic            ok;
    logic            br_ok;
    logic            op_ok;
    logic [4:0]      rt;
    logic [24:0]     fn;
    logic [XLEN-1:0] tgt;
    logic [XLEN-1:0] sx;
    logic            present_z;
    assign z = issue_instr[COPNUM_HI:COPNUM_LO];
    assign present_z = impl.ctl_reg_present[z];
    assign ok = mode.cop_usable_bit[z] || (z == 2'h0 &&
        (mode.privilege_level_field == PRIV_KERNEL || mode.exception_level_bit
        || mode.error_level_bit || mode.debug_active_bit));
    assign br_ok = ok && z != 2'h0 && impl.cond_branch_impl[z]
        && cop_cond[{z, issue_instr[20:18]}];
    assign op_ok = ok && impl.operate_impl[z] && issue_instr[CO_BIT];
    assign rt = issue_instr[RT_HI:RT_LO];
    assign fn = issue_instr[FUNC_HI:FUNC_LO];
    assign tgt = issue_pc + XLEN'(4)
        + {{(XLEN-18){issue_instr[15]}}, issue_instr[15:0], 2'b00};
    assign sx = {{(XLEN-CLEN){cop_ctl_data[CLEN-1]}}, cop_ctl_data};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // Assertions
    // ----
    a_deny_unusable: assert property (
        exc_valid && exc_code == CAG_EXC_UNUSABLE |-> !$past(ok)
        && exc_cop == $past(z)) else $error("unusable without denial");
    a_grant_reserved: assert property (
        exc_valid && exc_code == CAG_EXC_RESERVED |-> $past(ok)
        && exc_cop == $past(z)) else $error("reserved without access");
    a_target_sum: assert property (
        branch_taken |-> branch_target == $past(tgt))
        else $error("branch target wrong");
    a_branch_cond: assert property (
        branch_taken |-> $past(br_ok)) else $error("branch not allowed");
    a_read_sext: assert property (
        gpr_we |-> gpr_addr == $past(rt) && (gpr_wdata == $past(sx)
        || (gpr_wdata == '0 && !$past(present_z))))
        else $error("control read result wrong");
    a_op_func: assert property (
        cop_op_valid |-> $past(op_ok) && cop_op_func == $past(fn))
        else $error("operate wrong");
    a_one_result: assert property (
        $onehot0({exc_valid, branch_taken, gpr_we, cop_op_valid}))
        else $error("more than one result");
    a_quiet_idle: assert property (
        !$past(issue_valid) |-> !(exc_valid || branch_taken || gpr_we
        || cop_op_valid)) else $error("result without instruction");
    a_apb_ready: assert property (
        psel && penable |-> pready) else $error("bus not answered");
endmodule : cag_gate_assertions
`default_nettype wire

/* File: tb/cag_cop_model.sv */
// Partner: behavioural coprocessor bank
`timescale 1ns/1ps
`default_nettype none
module cag_cop_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [1:0]  cop_num,
    input  wire logic [4:0]  cop_ctl_addr,
    output logic      [31:0] cop_cond,
    output logic      [31:0] cop_ctl_data
);
    // Conditions change every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cop_cond <= 32'h9e37_79b9;
        end else begin
            cop_cond <= {cop_cond[30:0], cop_cond[31] ^ cop_cond[21]
                ^ cop_cond[1] ^ cop_cond[0]};
        end
    end
    // Control register, sign bit follows address
    assign cop_ctl_data = {cop_ctl_addr[0], 24'h5a3c96, cop_num,
        cop_ctl_addr};
endmodule : cag_cop_model
`default_nettype wire

/* File: tb/coprocessor_access_gate_bench.sv */
// Bench: random and corner stimulus for the access gate
`timescale 1ns/1ps
`default_nettype none
module coprocessor_access_gate_bench
    import cag_pkg::*;
;
    typedef struct packed {
        logic [3:0] f; logic [4:0] x; logic [63:0] t;
        logic [4:0] a; logic [63:0] d; logic [24:0] o;
    } cag_exp_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, issue_instr, cop_cond, cop_ctl_data, r;
    logic issue_valid, cop_op_valid, exc_valid, branch_taken, gpr_we, irq;
    logic [63:0] issue_pc, branch_target, gpr_wdata;
    cag_mode_t mode;
    cag_impl_t impl;
    logic [1:0] cop_num, exc_cop;
    logic [4:0] cop_ctl_addr, gpr_addr;
    logic [24:0] cop_op_func;
    cag_exc_t exc_code;
    logic en, zu, e;
    int fails, compares;
    int unsigned seed_val;
    cag_gate u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .issue_valid(issue_valid), .issue_instr(issue_instr),
        .issue_pc(issue_pc), .mode(mode), .impl(impl), .cop_cond(cop_cond),
        .cop_ctl_data(cop_ctl_data), .cop_num(cop_num), .exc_cop(exc_cop),
        .cop_ctl_addr(cop_ctl_addr), .cop_op_valid(cop_op_valid),
        .cop_op_func(cop_op_func), .exc_valid(exc_valid), .gpr_we(gpr_we),
        .exc_code(exc_code), .branch_taken(branch_taken), .gpr_addr(gpr_addr),
        .branch_target(branch_target), .gpr_wdata(gpr_wdata));
    cag_cop_model u_model (.pclk(pclk), .presetn(presetn), .cop_num(cop_num),
        .cop_ctl_addr(cop_ctl_addr), .cop_cond(cop_cond),
        .cop_ctl_data(cop_ctl_data));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ----
    // Tasks
    // ----
    task automatic tally_and_finish();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [63:0] g, input logic [63:0] x);
        compares++;
        if (g !== x) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            fails++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic cag_exp_t predict();
        cag_exp_t x;
        logic [1:0] z;
        logic [4:0] rs;
        logic al;
        x = '0;
        z = issue_instr[27:26];
        rs = issue_instr[25:21];
        al = mode.cop_usable_bit[z] || (z == 2'h0 &&
            (mode.privilege_level_field == 2'h0 || mode.exception_level_bit
            || mode.error_level_bit || mode.debug_active_bit));
        x.t = issue_pc + 64'h4
            + {{46{issue_instr[15]}}, issue_instr[15:0], 2'b00};
        x.a = issue_instr[20:16];
        x.d = (zu && !impl.ctl_reg_present[z]) ? 64'h0
            : {{32{cop_ctl_data[31]}}, cop_ctl_data};
        x.o = issue_instr[24:0];
        x.x = {al ? CAG_EXC_RESERVED : CAG_EXC_UNUSABLE, z};
        if (!issue_valid || !en || issue_instr[31:28] != 4'h4
            || (!issue_instr[25] && rs != 5'h02 && rs != 5'h08)) return x;
        if (!al) x.f = 4'b1000;
        else if (issue_instr[25]) x.f = impl.operate_impl[z] ? 4'h1 : 4'h8;
        else if (z == 2'h0) x.f = 4'b1000;
        else if (rs == 5'h02) x.f = impl.control_read_impl[z] ? 4'h2 : 4'h8;
        else if (!impl.cond_branch_impl[z]) x.f = 4'b1000;
        else x.f = {1'b0, cop_cond[{z, issue_instr[20:18]}], 2'b00};
        return x;
    endfunction : predict
    function automatic logic [31:0] rnd_instr();
        logic [31:0] v;
        v = $urandom;
        v[31:28] = 4'h4;
        case ($urandom_range(0, 4))
            0: v[25:21] = 5'h02;
            1: v[25:21] = 5'h08;
            2: v[25] = 1'b1;
            3: v[31:28] = 4'h6;
            default: v[25:21] = 5'h04;
        endcase
        return v;
    endfunction : rnd_instr
    task automatic check_out(input cag_exp_t x);
        cmp(64'({exc_valid, branch_taken, gpr_we, cop_op_valid}), 64'(x.f));
        if (x.f[3]) cmp(64'({exc_code, exc_cop}), 64'(x.x));
        if (x.f[2]) cmp(branch_target, x.t);
        if (x.f[1]) cmp(gpr_wdata, x.d);
        if (x.f[1]) cmp(64'(gpr_addr), 64'(x.a));
        if (x.f[0]) cmp(64'(cop_op_func), 64'(x.o));
    endtask : check_out
    task automatic run_random(input int n);
        cag_exp_t x;
        x = '0;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            issue_valid <= $urandom_range(0, 3) != 0;
            issue_instr <= rnd_instr();
            issue_pc <= {$urandom, $urandom};
            mode <= cag_mode_t'($urandom);
            impl <= cag_impl_t'($urandom);
            @(negedge pclk);
            check_out(x);
            x = predict();
        end
        @(posedge pclk);
        issue_valid <= 1'b0;
        @(negedge pclk);
        check_out(x);
        $display("test random done");
    endtask : run_random
    // ----
    // Main sequence
    // ----
    initial begin
        {fails, compares, en, zu, presetn, psel, penable, pwrite} = '0;
        {paddr, pwdata, issue_valid, issue_instr, issue_pc} = '0;
        mode = '0;
        impl = '0;
        seed_val = $urandom(77);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_MASK, 32'h0);
        cmp(64'(r), 64'(MASK_RST));
        apb(1'b0, OFS_CTRL, 32'h0);
        cmp(64'(r), 64'(CTRL_RST));
        run_random(20);
        apb(1'b1, OFS_CTRL, 32'h1);
        en = 1'b1;
        run_random(400);
        apb(1'b1, OFS_CTRL, 32'h3);
        zu = 1'b1;
        run_random(400);
        apb(1'b1, OFS_MASK, 32'h0);
        apb(1'b1, OFS_STATUS, 32'h1f);
        apb(1'b1, OFS_CTRL, 32'h7);
        mode <= cag_mode_t'(9'h180);
        @(posedge pclk);
        issue_valid <= 1'b1;
        issue_instr <= 32'h4500_0000;
        @(posedge pclk);
        issue_valid <= 1'b0;
        repeat (2) @(negedge pclk);
        cmp(64'(irq), 64'h0);
        apb(1'b1, OFS_MASK, 32'h1 << EV_UNUSABLE);
        @(negedge pclk);
        cmp(64'(irq), 64'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp(64'(r[EV_UNUSABLE]), 64'h1);
        apb(1'b0, OFS_LAST, 32'h0);
        cmp(64'(r), 64'({2'h1, CAG_EXC_UNUSABLE}));
        apb(1'b0, OFS_COUNT, 32'h0);
        cmp(64'(r), 64'h1);
        apb(1'b1, OFS_STATUS, 32'h1 << EV_UNUSABLE);
        @(negedge pclk);
        cmp(64'(irq), 64'h0);
        apb(1'b0, 12'h0f0, 32'h0);
        cmp({31'h0, e, r}, {31'h0, 1'b1, 32'h0});
        $display("test irq and bus done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(negedge pclk);
        cmp(64'({exc_valid, branch_taken, gpr_we, irq}), 64'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        {en, zu} = 2'b00;
        run_random(20);
        tally_and_finish();
    end
endmodule : coprocessor_access_gate_bench
bind cag_gate cag_gate_assertions #(.XLEN(XLEN), .CLEN(CLEN)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .issue_pc(issue_pc), .mode(mode), .impl(impl), .cop_cond(cop_cond),
    .cop_ctl_data(cop_ctl_data), .exc_valid(exc_valid), .exc_code(exc_code),
    .exc_cop(exc_cop), .branch_taken(branch_taken), .gpr_we(gpr_we),
    .branch_target(branch_target), .gpr_addr(gpr_addr),
    .gpr_wdata(gpr_wdata), .cop_op_valid(cop_op_valid),
    .cop_op_func(cop_op_func));
`default_nettype wire
